// ===== pkg/power_seq_pkg.sv
// Package: states, timing constants and status carrier of the power-state sequencer
package power_seq_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ          = 64'd200_000_000;
	localparam longint unsigned ON_HOLD_S       = 64'd5;
	localparam longint unsigned OFF_HOLD_S      = 64'd3;
	localparam longint unsigned ON_HOLD_CYCLES  = ON_HOLD_S * CLK_HZ;
	localparam longint unsigned OFF_HOLD_CYCLES = OFF_HOLD_S * CLK_HZ;
	localparam int unsigned     CNT_W           = 32;
	localparam int unsigned     SYNC_STAGES     = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [2:0] SYNC_RESET = 3'h7;
	localparam logic [31:0] CNT_RESET = 32'h0;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OFF      = 5'h01,
		ST_ON       = 5'h02,
		ST_SLEEP    = 5'h04,
		ST_DEEP     = 5'h08,
		ST_SHUTDOWN = 5'h10
	} power_state_e;

	typedef struct packed {
		logic rtc_run;
		logic baseband_on;
		logic cmd_accept;
		logic cpu_intermittent;
	} power_status_s;

endpackage

// ===== hw/power_state_sequencer.sv
// Power-state sequencer: power key / wake input, off/on/sleep/deep sleep, monitor outputs
module power_state_sequencer
	import power_seq_pkg::*;
#(
	parameter longint unsigned ON_HOLD  = ON_HOLD_CYCLES,
	parameter longint unsigned OFF_HOLD = OFF_HOLD_CYCLES
) (
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	input  wire logic          power_key_n,
	input  wire logic          supply_ok,
	input  wire logic          psm_enable,
	input  wire logic          sleep_req,
	input  wire logic          deep_sleep_req,
	input  wire logic          wake_timer,
	input  wire logic          shutdown_done,
	output logic               power_on_indicator,
	output logic               aux_supply_out,
	output power_status_s      status
);

	// ------------------------------------------------------------
	// Key synchroniser, three stages; stage 0 feeds only stage 1
	// ------------------------------------------------------------
	logic [2:0] key_sync;
	logic [2:0] next_key_sync;
	logic       key_low;
	logic       next_key_low;

	always_comb begin
		next_key_sync = {key_sync[1:0], power_key_n};
		next_key_low  = key_low;
		if (key_sync[1] == key_sync[2]) begin
			next_key_low = ~key_sync[2];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			key_sync <= SYNC_RESET;
			key_low  <= 1'b0;
		end else begin
			key_sync <= next_key_sync;
			key_low  <= next_key_low;
		end
	end

	// ------------------------------------------------------------
	// Hold counter, saturating so a very long press cannot wrap
	// ------------------------------------------------------------
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;
	logic             on_long;
	logic             off_long;

	assign on_long  = 64'(hold_cnt) >= ON_HOLD - 64'd1;
	assign off_long = 64'(hold_cnt) >= OFF_HOLD - 64'd1;

	always_comb begin
		next_hold_cnt = CNT_RESET;
		if (key_low) begin
			next_hold_cnt = (&hold_cnt) ? hold_cnt : hold_cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_cnt <= CNT_RESET;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	power_state_e  state;
	power_state_e  next_state;
	logic          armed;
	logic          next_armed;
	logic          wait_release;
	logic          next_wait_release;
	logic          next_pmon;
	logic          next_aux;
	power_status_s next_status;

	always_comb begin
		next_state        = state;
		next_armed        = armed;
		next_wait_release = wait_release && key_low;
		if (!supply_ok) begin
			next_state        = ST_OFF;
			next_armed        = 1'b0;
			next_wait_release = 1'b0;
		end else begin
			unique case (state)
				ST_OFF: begin
					// Power on waits for the release after a long enough press
					if (key_low && on_long) begin
						next_armed = 1'b1;
					end
					if (!key_low && armed) begin
						next_state = ST_ON;
						next_armed = 1'b0;
					end
				end
				ST_ON, ST_SLEEP: begin
					// A waking press has already passed the off time, so it must be released first
					if (key_low && off_long && !wait_release) begin
						next_state = ST_SHUTDOWN;
					end else if (state == ST_ON && deep_sleep_req) begin
						next_state = ST_DEEP;
					end else if (state == ST_ON && sleep_req) begin
						next_state = ST_SLEEP;
					end else if (state == ST_SLEEP && !sleep_req) begin
						next_state = ST_ON;
					end
				end
				ST_DEEP: begin
					if ((key_low && on_long) || wake_timer) begin
						next_state        = ST_ON;
						next_wait_release = key_low;
					end
				end
				ST_SHUTDOWN: begin
					if (shutdown_done) begin
						next_state = ST_OFF;
					end
				end
			endcase
		end
		// Monitor follows the next state so it never lags the state register
		next_pmon = (next_state != ST_OFF);
		next_aux  = next_pmon && !(next_state == ST_DEEP && psm_enable);
		next_status.rtc_run          = supply_ok;
		next_status.baseband_on      = (next_state == ST_ON) ||
		                               (next_state == ST_SLEEP) ||
		                               (next_state == ST_SHUTDOWN);
		next_status.cmd_accept       = (next_state == ST_ON) || (next_state == ST_SLEEP);
		next_status.cpu_intermittent = (next_state == ST_SLEEP);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state              <= ST_OFF;
			armed              <= 1'b0;
			wait_release       <= 1'b0;
			power_on_indicator <= 1'b0;
			aux_supply_out     <= 1'b0;
			status             <= '0;
		end else begin
			state              <= next_state;
			armed              <= next_armed;
			wait_release       <= next_wait_release;
			power_on_indicator <= next_pmon;
			aux_supply_out     <= next_aux;
			status             <= next_status;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_release_armed;
		armed && !key_low && supply_ok;
	endsequence

	AST_POWER_ON: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_OFF) and s_release_armed |=> (state == ST_ON) && power_on_indicator)
		else $error("power on did not follow a long press release");

	AST_OFF_ONLY_TO_ON: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_OFF) |=> (state == ST_OFF) || (state == ST_ON))
		else $error("off left to a state other than on");

	AST_SHORT_PRESS: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_OFF) && !armed && !key_low |=> (state == ST_OFF))
		else $error("off left without a qualifying press");

	AST_DEEP_WAKE: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_DEEP) && key_low && on_long && supply_ok |=> (state == ST_ON))
		else $error("deep sleep did not wake on long press");

	AST_PMON_ON: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_ON) |-> power_on_indicator)
		else $error("monitor low while on");

	AST_AUX_DEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_DEEP) && $past(psm_enable) |-> !aux_supply_out)
		else $error("aux supply on during deep sleep");

	AST_POWER_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_ON) && key_low && off_long && !wait_release && supply_ok
		|=> (state == ST_SHUTDOWN))
		else $error("long press did not start power off");

	AST_WAKE_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		wait_release |=> (state != ST_SHUTDOWN))
		else $error("waking press taken as power off");

	AST_PMON_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_SHUTDOWN) && shutdown_done && supply_ok
		|=> !power_on_indicator && (state == ST_OFF))
		else $error("monitor still high after power off");

	AST_CMD_ACCEPT: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_ON) |-> status.cmd_accept && status.baseband_on)
		else $error("on state without full baseband");

	AST_SLEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_SLEEP) |-> status.cpu_intermittent && status.cmd_accept)
		else $error("sleep state flags wrong");

	AST_DEEP_BB: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_DEEP) |-> !status.baseband_on)
		else $error("baseband on in deep sleep");

	AST_RTC: assert property (@(posedge ref_clk) disable iff (!nrst)
		!supply_ok |=> (state == ST_OFF) && !status.rtc_run)
		else $error("supply loss not handled");

endmodule

// ===== verification/host_key_model.sv
// Host model: push-pull driver of the power key / wake line
module host_key_model (
	input  wire logic pull,
	output wire logic power_key_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Wire level
	// ------------------------------------------------------------
	// Driven high when released: the line does not rely on a device pull-up
	assign power_key_n = pull ? 1'h0 : 1'h1;
endmodule

// ===== verification/test_power_state_sequencer.sv
// Testbench: power-state sequencer with host key model, monitor outputs checked from a queue, status flags checked directly
module test_power_state_sequencer
	import power_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int  ON_N = 50;
	localparam int  OFF_N = 30;
	logic           ref_clk = 1'h0;
	logic           nrst = 1'h0;
	logic           pull = 1'h0;
	logic           supply_ok = 1'h1;
	logic           psm_enable = 1'h1;
	logic           sleep_req = 1'h0;
	logic           deep_sleep_req = 1'h0;
	logic           wake_timer = 1'h0;
	logic           shutdown_done = 1'h0;
	wire            key_n;
	logic           ind;
	logic           aux;
	power_status_s  status;
	logic [1:0]     exp_q[$];
	logic [1:0]     last = 2'h0;
	int             error_cnt = 0;
	int             num_checks = 0;
	int             cyc = 0;
	// ------------------------------------------------------------
	// Clock, design and host
	// ------------------------------------------------------------
	initial forever #2.5 ref_clk = ~ref_clk;
	host_key_model i_host (.pull(pull), .power_key_n(key_n));
	power_state_sequencer #(.ON_HOLD(ON_N), .OFF_HOLD(OFF_N)) i_dut (
		.ref_clk(ref_clk), .nrst(nrst), .power_key_n(key_n), .supply_ok(supply_ok),
		.psm_enable(psm_enable), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
		.wake_timer(wake_timer), .shutdown_done(shutdown_done),
		.power_on_indicator(ind), .aux_supply_out(aux), .status(status));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic press(input int n);
		pull = 1'h1;
		repeat (n) @(negedge ref_clk);
		pull = 1'h0;
		repeat (80) @(negedge ref_clk);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Watcher: any change of the monitor pair must match the oldest note
	// ------------------------------------------------------------
	// Sampled on the falling edge so registered outputs have settled
	always @(negedge ref_clk) begin
		if (nrst && {ind, aux} !== last) begin
			if (exp_q.size() == 0) check({ind, aux}, ~{ind, aux});
			else check({ind, aux}, exp_q.pop_front());
		end
		last <= {ind, aux};
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			results();
		end
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		void'($urandom(75));
		repeat (3) @(negedge ref_clk);
		nrst = 1'h1;
		repeat (3) @(negedge ref_clk);
		check({1'h0, status.rtc_run}, 2'h1);
		repeat (10) begin
			{deep_sleep_req, wake_timer, sleep_req, shutdown_done, psm_enable} = 5'($urandom);
			@(negedge ref_clk);
		end
		deep_sleep_req = 1'h1;
		wake_timer = 1'h1;
		sleep_req = 1'h1;
		repeat (10) @(negedge ref_clk);
		deep_sleep_req = 1'h0;
		wake_timer = 1'h0;
		sleep_req = 1'h0;
		shutdown_done = 1'h0;
		psm_enable = 1'h1;
		press(10 + $urandom % 25);
		exp_q.push_back(2'h3);
		press(ON_N + 5 + $urandom % 20);
		check({status.cmd_accept, status.baseband_on}, 2'h3);
		sleep_req = 1'h1;
		repeat (20) @(negedge ref_clk);
		check({status.cpu_intermittent, status.cmd_accept}, 2'h3);
		sleep_req = 1'h0;
		press(5 + $urandom % 20);
		exp_q.push_back(2'h2);
		deep_sleep_req = 1'h1;
		repeat (10) @(negedge ref_clk);
		deep_sleep_req = 1'h0;
		repeat (10) @(negedge ref_clk);
		check({status.baseband_on, status.cmd_accept}, 2'h0);
		exp_q.push_back(2'h3);
		wake_timer = 1'h1;
		@(negedge ref_clk);
		wake_timer = 1'h0;
		repeat (10) @(negedge ref_clk);
		exp_q.push_back(2'h2);
		deep_sleep_req = 1'h1;
		repeat (10) @(negedge ref_clk);
		deep_sleep_req = 1'h0;
		exp_q.push_back(2'h3);
		press(ON_N + 1);
		psm_enable = 1'h0;
		deep_sleep_req = 1'h1;
		repeat (10) @(negedge ref_clk);
		check({ind, aux}, 2'h3);
		deep_sleep_req = 1'h0;
		wake_timer = 1'h1;
		@(negedge ref_clk);
		wake_timer = 1'h0;
		press(OFF_N + 10);
		exp_q.push_back(2'h0);
		shutdown_done = 1'h1;
		repeat (10) @(negedge ref_clk);
		shutdown_done = 1'h0;
		repeat (10) @(negedge ref_clk);
		check({1'h0, exp_q.size() != 0}, 2'h0);
		exp_q.push_back(2'h3);
		press(ON_N + 5 + $urandom % 20);
		exp_q.push_back(2'h0);
		supply_ok = 1'h0;
		repeat (2 + $urandom % 4) @(negedge ref_clk);
		check({status.rtc_run, status.baseband_on}, 2'h0);
		supply_ok = 1'h1;
		repeat (3) @(negedge ref_clk);
		check({status.rtc_run, status.baseband_on}, 2'h2);
		check({1'h0, exp_q.size() != 0}, 2'h0);
		results();
	end
endmodule
